// ---- core/llc_pkg.sv ----
// llc_pkg: constants for the light-load and latch-off control block.
// assumes a 20 MHz logic clock; analogue levels arrive as comparator flags and a coded feedback word.
package llc_pkg;
	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_HZ           = 20000000;
	localparam int HI_BLANK_US      = 50;
	localparam int LO_BLANK_US      = 350;
	localparam int HI_BLANK_CYC     = (HI_BLANK_US * (CLK_HZ / 1000000));
	localparam int LO_BLANK_CYC     = (LO_BLANK_US * (CLK_HZ / 1000000));
	localparam int SSTART_US        = 4000;
	localparam int SS_STEPS         = 15;
	localparam int SS_STEP_CYC      = (SSTART_US * (CLK_HZ / 1000000)) / SS_STEPS;
	localparam int NOM_FREQ_HZ      = 65000;
	localparam int MIN_FREQ_HZ      = 25000;
	localparam int MAX_DUTY_PCT     = 80;
	// ------------------------------------------------------------
	// feedback levels, coded 8 bit word
	// ------------------------------------------------------------
	localparam int FB_W             = 8;
	localparam logic [7:0] FB_FOLD_START = 8'h60;
	localparam logic [7:0] FB_FOLD_END   = 8'h30;
	localparam logic [7:0] FB_SKIP_IN    = 8'h20;
	localparam logic [7:0] FB_SKIP_OUT   = 8'h28;
	localparam int SS_W             = 4;
	typedef enum logic [2:0] {LLC_OFF, LLC_HICHK, LLC_SSTART, LLC_RUN, LLC_SKIP, LLC_LATCH} llc_state_e;
endpackage

// ---- core/llc_blank.sv ----
// llc_blank: excursion filter; output rises only after the input stays high for CYC cycles.
// assumes a synchronised input on the same clock.
`timescale 1ns/1ns
module llc_blank
	import llc_pkg::*;
#(
	parameter int CYC = 1000
) (
	input  wire logic clk,   // logic clock
	input  wire logic rst,   // sync reset
	input  wire logic ce,    // clock enable
	input  wire logic clr,   // hold filter idle
	input  wire logic din,   // raw trip flag
	output logic      dout   // filtered trip
);
	if (CYC < 1) $error("CYC must be at least 1");
	logic [$clog2(CYC+1)-1:0] cnt_r, cnt_nxt;
	logic                     out_r, out_nxt;
	always_comb begin
		cnt_nxt = cnt_r;
		out_nxt = out_r;
		if (clr || !din) begin
			cnt_nxt = '0;
			out_nxt = 1'b0;
		end else if (cnt_r == ($clog2(CYC+1))'(CYC - 1)) begin
			out_nxt = 1'b1;
		end else begin
			cnt_nxt = cnt_r + 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_r <= '0;
			out_r <= 1'b0;
		end else if (ce) begin
			cnt_r <= cnt_nxt;
			out_r <= out_nxt;
		end
	end
	assign dout = out_r;
endmodule

// ---- core/llc_ctrl.sv ----
// llc_ctrl: light-load foldback, skip mode, latch-off window and thermal shutdown sequencing.
// assumes comparator flags from the analogue front end; the current comparator is outside too, this block runs the pwm oscillator and drive.
//
// Behaviour
// - fold frequency linearly below foldback start level
// - peak current regulation stays active during foldback
// - no foldback while max duty terminates cycles
// - skip entry stops drive, cuts consumption
// - skip exit restarts drive above exit threshold
// - run only inside latch window, else latch
// - blank high 50us, low 350us excursions
// - only supply reset releases latch; overtemperature shutdown also releases it here
// - ignore latch input before ready to start
// - check high trip at turn-on first
// - honour low trip after soft-start only
// - double thermistor bias during soft-start
// - overtemperature stops switching, startup source, resets
// - cool-down re-enables startup source, normal start
// - soft-start staircase of 15 steps
`timescale 1ns/1ns
module llc_ctrl
	import llc_pkg::*;
#(
	parameter int HI_CYC   = HI_BLANK_CYC,
	parameter int LO_CYC   = LO_BLANK_CYC,
	parameter int STEP_CYC = SS_STEP_CYC,
	parameter int OSC_NOM  = CLK_HZ / NOM_FREQ_HZ,
	parameter int OSC_MAX  = CLK_HZ / MIN_FREQ_HZ
) (
	input  wire logic            clk,              // 20 MHz logic clock
	input  wire logic            rst,              // sync reset, active high
	input  wire logic            ce,               // clock enable
	input  wire logic            supply_on,        // supply reached turn-on level (pin domain)
	input  wire logic            supply_reset,     // supply fell to reset voltage (pin domain)
	input  wire logic            upper_trip,       // latch input above upper trip level (pin domain)
	input  wire logic            lower_trip,       // latch input below lower trip level (pin domain)
	input  wire logic            overtemp_hi,      // die above upper shutdown threshold (pin domain)
	input  wire logic            overtemp_lo,      // die below lower shutdown threshold (pin domain)
	input  wire logic            peak_reached,     // current sense hit setpoint (pin domain)
	input  wire logic [FB_W-1:0] feedback_input,   // coded feedback level (pin domain)
	output logic                 gate_drive_output,// drive to power switch
	output logic                 hv_startup_en,    // high_voltage_startup_pin source on
	output logic                 low_power,        // reduced internal consumption
	output logic                 ntc_double,       // softstart_bias_current selected
	output logic [SS_W-1:0]      ss_step,          // soft-start setpoint step
	output logic                 latched           // latched-off state
);
	if (OSC_MAX <= OSC_NOM || STEP_CYC < 1) $error("bad timing parameters");
	localparam int PW = $clog2(OSC_MAX + 1);
	localparam int SW = $clog2(STEP_CYC + 1);

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	localparam int NS = 8 + FB_W;
	logic [NS-1:0] s1_r, s2_r;
	always_ff @(posedge clk) begin
		if (rst) begin
			s1_r <= '0;
			s2_r <= '0;
		end else if (ce) begin
			s1_r <= {feedback_input, peak_reached, overtemp_lo, overtemp_hi,
				lower_trip, upper_trip, supply_reset, supply_on, 1'b0};
			s2_r <= s1_r;
		end
	end
	logic [FB_W-1:0] fb;
	logic peak_s, otl_s, oth_s, lo_s, hi_s, vrst_s, von_s;
	assign {fb, peak_s, otl_s, oth_s, lo_s, hi_s, vrst_s, von_s} = s2_r[NS-1:1];

	// ------------------------------------------------------------
	// state and filters
	// ------------------------------------------------------------
	llc_state_e st_r, st_nxt;
	logic hi_f, lo_f, hot_r, hot_nxt;
	wire  ready = (st_r != LLC_OFF);
	llc_blank #(.CYC(HI_CYC)) u_hi (.clk(clk), .rst(rst), .ce(ce),
		.clr(!ready), .din(hi_s), .dout(hi_f));
	llc_blank #(.CYC(LO_CYC)) u_lo (.clk(clk), .rst(rst), .ce(ce),
		.clr(!(st_r == LLC_RUN || st_r == LLC_SKIP)), .din(lo_s), .dout(lo_f));

	// period selection: linear between fold start and fold end
	function automatic logic [PW-1:0] period_of(input logic [FB_W-1:0] v);
		logic [31:0] span;
		span = 32'(OSC_MAX - OSC_NOM);
		if (v >= FB_FOLD_START)
			return PW'(OSC_NOM);
		else if (v <= FB_FOLD_END)
			return PW'(OSC_MAX);
		else
			return PW'(32'(OSC_NOM) + span * 32'(FB_FOLD_START - v) / 32'(FB_FOLD_START - FB_FOLD_END));
	endfunction

	// ------------------------------------------------------------
	// oscillator, duty and drive
	// ------------------------------------------------------------
	logic [PW-1:0]   ph_r, ph_nxt, per_r, per_nxt;
	logic [SW-1:0]   sc_r, sc_nxt;
	logic [SS_W-1:0] ss_r, ss_nxt;
	logic            drv_r, drv_nxt, maxd_r, maxd_nxt;
	logic            hv_r, hv_nxt, lp_r, lp_nxt, nd_r, nd_nxt;
	wire             switching = (st_r == LLC_SSTART || st_r == LLC_RUN);

	always_comb begin
		st_nxt   = st_r;
		hot_nxt  = hot_r;
		ph_nxt   = ph_r;
		per_nxt  = per_r;
		sc_nxt   = sc_r;
		ss_nxt   = ss_r;
		drv_nxt  = 1'b0;
		maxd_nxt = maxd_r;
		unique case (st_r)
			LLC_OFF: begin
				if (von_s && !hot_r)
					st_nxt = LLC_HICHK;
			end
			LLC_HICHK: begin
				if (hi_s)
					st_nxt = LLC_LATCH;
				else
					st_nxt = LLC_SSTART;
			end
			LLC_SSTART: begin
				if (sc_r == SW'(STEP_CYC - 1)) begin
					sc_nxt = '0;
					if (ss_r == SS_W'(SS_STEPS))
						st_nxt = LLC_RUN;
					else
						ss_nxt = ss_r + 1'b1;
				end else begin
					sc_nxt = sc_r + 1'b1;
				end
			end
			LLC_RUN: begin
				if (fb <= FB_SKIP_IN)
					st_nxt = LLC_SKIP;
			end
			LLC_SKIP: begin
				if (fb > FB_SKIP_OUT)
					st_nxt = LLC_RUN;
			end
			LLC_LATCH: ;
		endcase
		if (switching) begin
			if (ph_r >= per_r - 1'b1) begin
				ph_nxt = '0;
				// no foldback, nominal period, while the previous cycle ended on max duty
				per_nxt = maxd_r ? PW'(OSC_NOM) : period_of(fb);
				maxd_nxt = 1'b0;
			end else begin
				ph_nxt = ph_r + 1'b1;
			end
			// on from phase 0 until peak current or max duty ends the cycle
			// duty limit judged on the next phase, else the wrap itself would keep drive off
			if (ph_nxt == '0)
				drv_nxt = 1'b1;
			else if (drv_r && peak_s)
				drv_nxt = 1'b0;
			else if (ph_nxt >= PW'((32'(per_r) * MAX_DUTY_PCT) / 100)) begin
				drv_nxt = 1'b0;
				if (drv_r)
					maxd_nxt = 1'b1;
			end else
				drv_nxt = drv_r;
		end else begin
			ph_nxt = '0;
		end
		if (ready && st_r != LLC_LATCH && (hi_f || lo_f))
			st_nxt = LLC_LATCH;
		if (!(st_r == LLC_SSTART || st_r == LLC_HICHK)) begin
			ss_nxt = (st_r == LLC_OFF) ? '0 : ss_r;
			sc_nxt = '0;
		end
		if (oth_s) begin
			hot_nxt = 1'b1;
			st_nxt  = LLC_OFF;
			drv_nxt = 1'b0;
			ss_nxt  = '0;
		end else if (otl_s)
			hot_nxt = 1'b0;
		if (vrst_s) begin
			st_nxt  = LLC_OFF;
			drv_nxt = 1'b0;
		end
		if (st_nxt == LLC_LATCH)
			drv_nxt = 1'b0;
		hv_nxt = !hot_nxt;
		lp_nxt = (st_nxt == LLC_SKIP);
		nd_nxt = (st_nxt == LLC_SSTART);
		if (st_nxt == LLC_SKIP)
			drv_nxt = 1'b0;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r   <= LLC_OFF;
			hot_r  <= 1'b0;
			ph_r   <= '0;
			per_r  <= PW'(OSC_NOM);
			sc_r   <= '0;
			ss_r   <= '0;
			drv_r  <= 1'b0;
			maxd_r <= 1'b0;
			hv_r   <= 1'b1;
			lp_r   <= 1'b0;
			nd_r   <= 1'b0;
		end else if (ce) begin
			st_r   <= st_nxt;
			hot_r  <= hot_nxt;
			ph_r   <= ph_nxt;
			per_r  <= per_nxt;
			sc_r   <= sc_nxt;
			ss_r   <= ss_nxt;
			drv_r  <= drv_nxt;
			maxd_r <= maxd_nxt;
			hv_r   <= hv_nxt;
			lp_r   <= lp_nxt;
			nd_r   <= nd_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	logic lat_r;
	always_ff @(posedge clk) begin
		if (rst)
			lat_r <= 1'b0;
		else if (ce)
			lat_r <= (st_nxt == LLC_LATCH);
	end
	assign gate_drive_output = drv_r;
	assign hv_startup_en     = hv_r;
	assign low_power         = lp_r;
	assign ntc_double        = nd_r;
	assign ss_step           = ss_r;
	assign latched           = lat_r;
endmodule

// ---- testbench/llc_ctrl_checker.sv ----
// llc_ctrl_checker: port-level checks of the light-load and latch-off control.
// assumes ce held high, so cycle counts below are clock counts.
`timescale 1ns/1ns
module llc_ctrl_checker
	import llc_pkg::*;
(
	input wire logic            clk,               // clock
	input wire logic            rst,               // sync reset
	input wire logic            supply_reset,      // supply low
	input wire logic            upper_trip,        // upper trip
	input wire logic            lower_trip,        // lower trip
	input wire logic            overtemp_hi,       // die hot
	input wire logic [FB_W-1:0] feedback_input,    // feedback
	input wire logic            gate_drive_output, // drive
	input wire logic            hv_startup_en,     // startup source
	input wire logic            low_power,         // skip mode
	input wire logic            ntc_double,        // doubled bias
	input wire logic [SS_W-1:0] ss_step,           // soft-start step
	input wire logic            latched            // latched off
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_latch_drive_low: assert property (latched |-> !gate_drive_output)
		else $error("drive high while latched");
	a_latch_release: assert property ($fell(latched) |-> $past(supply_reset, 2) || $past(supply_reset, 3)
		|| $past(supply_reset, 4) || $past(overtemp_hi, 2) || $past(overtemp_hi, 3) || $past(overtemp_hi, 4))
		else $error("latch released without supply reset");
	a_latch_cause: assert property ($rose(latched) |-> $past(upper_trip, 3) || $past(upper_trip, 4)
		|| $past(lower_trip, 4))
		else $error("latch without trip");
	a_skip_no_drive: assert property (low_power |-> !gate_drive_output)
		else $error("drive during skip");
	a_skip_exit: assert property (not ((low_power && feedback_input > FB_SKIP_OUT)[*6]))
		else $error("skip kept above exit level");
	a_hot_stop: assert property (overtemp_hi[*5] |-> !gate_drive_output && !hv_startup_en)
		else $error("running while hot");
	a_ss_stairs: assert property ($changed(ss_step) |-> ss_step == $past(ss_step) + 4'h1 || ss_step == 4'h0)
		else $error("soft-start step jumped");
	a_ntc_sstart: assert property (ntc_double |-> !low_power && !latched)
		else $error("doubled bias outside soft-start");
endmodule
bind llc_ctrl llc_ctrl_checker chk_i (.clk, .rst, .supply_reset, .upper_trip, .lower_trip, .overtemp_hi,
	.feedback_input, .gate_drive_output, .hv_startup_en, .low_power, .ntc_double, .ss_step, .latched);

// ---- testbench/llc_switch_model.sv ----
// llc_switch_model: power switch and current sense behind the gate drive.
// assumes one clock; peak comes RAMP cycles after turn-on unless stalled.
`timescale 1ns/1ns
module llc_switch_model #(
	parameter int RAMP = 3
) (
	input  wire logic clk,   // clock
	input  wire logic gate,  // gate drive
	input  wire logic stall, // no peak, cycles end by duty limit
	output logic      peak   // current at setpoint
);
	int n;
	always_ff @(posedge clk) begin
		n <= gate ? n + 1 : 0;
	end
	// current collapses as soon as the switch opens
	assign peak = gate && !stall && n >= RAMP;
endmodule

// ---- testbench/llc_ctrl_test.sv ----
// llc_ctrl_test: self-checking bench of llc_ctrl with shortened counts.
// assumes the switch model on the drive and the checker bound in.
`timescale 1ns/1ns
module llc_ctrl_test
	import llc_pkg::*;
;
	logic clk = 1'b0, rst = 1'b1, ce = 1'b1, supply_on = 1'b0, supply_reset = 1'b0, stall = 1'b0;
	logic upper_trip = 1'b0, lower_trip = 1'b0, overtemp_hi = 1'b0, overtemp_lo = 1'b0;
	logic [7:0] feedback_input = 8'hFF;
	logic peak_reached, gate_drive_output, hv_startup_en, low_power, ntc_double, latched;
	logic [3:0] ss_step;
	int failures = 0, n_checks = 0, p, i, k;
	// fb, period, skip
	logic [23:0] rows [11] = '{24'hFF0A00, 24'h600A00, 24'h480F00, 24'h301400, 24'h211400, 24'h200001,
		24'h240001, 24'h280001, 24'h291400, 24'h1F0001, 24'h301400};
	llc_ctrl #(.HI_CYC(4), .LO_CYC(8), .STEP_CYC(4), .OSC_NOM(10), .OSC_MAX(20)) uut (.clk, .rst, .ce,
		.supply_on, .supply_reset, .upper_trip, .lower_trip, .overtemp_hi, .overtemp_lo, .peak_reached,
		.feedback_input, .gate_drive_output, .hv_startup_en, .low_power, .ntc_double, .ss_step, .latched);
	llc_switch_model sw (.clk, .gate(gate_drive_output), .stall, .peak(peak_reached));
	always #25 clk = ~clk;
	task cy(input int n);
		repeat (n) @(posedge clk);
		#5;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task give_verdict;
		$display("checks=%0d failures=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic wu(ref logic s, input logic v);
		for (k = 0; k < 400 && s !== v; k++) cy(1);
		if (s !== v) begin
			failures++;
			give_verdict;
		end
	endtask
	// on time and rise-to-rise period of one drive cycle
	task per(output int on, output int n);
		wu(gate_drive_output, 1'b0);
		wu(gate_drive_output, 1'b1);
		for (n = 0; n < 99 && gate_drive_output === 1'b1; n++) cy(1);
		on = n;
		for (; n < 99 && gate_drive_output !== 1'b1; n++) cy(1);
	endtask
	initial begin
		cy(6);
		rst = 1'b0;
		chk({ss_step, latched, gate_drive_output, hv_startup_en, low_power}, 8'h02);
		chk(ntc_double, 1'b0);
		upper_trip = 1'b1;
		lower_trip = 1'b1;
		cy(30);
		chk(latched, 1'b0);
		upper_trip = 1'b0;
		supply_on = 1'b1;
		wu(ntc_double, 1'b1);
		cy(20);
		lower_trip = 1'b0;
		chk(latched, 1'b0);
		wu(ntc_double, 1'b0);
		chk(k >= 40 && k <= 46, 1'b1);
		$display("startup test done");
		for (int r = 0; r < 11; r++) begin
			feedback_input = rows[r][23:16];
			cy(30);
			chk(low_power, rows[r][7:0]);
			if (rows[r][0]) chk(gate_drive_output, 1'b0);
			else begin
				per(i, p);
				chk(8'(p), rows[r][15:8]);
				chk(i < 8, 1'b1);
			end
		end
		stall = 1'b1;
		cy(30);
		per(i, p);
		chk(8'(p), 8'h0A);
		chk(8'(i), 8'h08);
		stall = 1'b0;
		$display("light load test done");
		upper_trip = 1'b1;
		cy(2);
		upper_trip = 1'b0;
		lower_trip = 1'b1;
		cy(6);
		lower_trip = 1'b0;
		cy(12);
		chk(latched, 1'b0);
		lower_trip = 1'b1;
		cy(20);
		chk(latched, 1'b1);
		lower_trip = 1'b0;
		feedback_input = 8'hFF;
		cy(40);
		chk({latched, gate_drive_output}, 8'h02);
		supply_reset = 1'b1;
		supply_on = 1'b0;
		cy(4);
		supply_reset = 1'b0;
		upper_trip = 1'b1;
		cy(4);
		chk(latched, 1'b0);
		supply_on = 1'b1;
		cy(20);
		chk({latched, ntc_double}, 8'h02);
		supply_reset = 1'b1;
		upper_trip = 1'b0;
		cy(4);
		supply_reset = 1'b0;
		$display("latch test done");
		wu(ntc_double, 1'b1);
		wu(ntc_double, 1'b0);
		overtemp_hi = 1'b1;
		cy(8);
		chk({hv_startup_en, gate_drive_output}, 8'h00);
		overtemp_hi = 1'b0;
		overtemp_lo = 1'b1;
		wu(hv_startup_en, 1'b1);
		wu(ntc_double, 1'b1);
		$display("thermal test done");
		give_verdict;
	end
endmodule
